// *** hdl/asp_host.sv ***
// Host sequencer that drives an asynchronous 512K x 8 SRAM through its pins.
`timescale 1ns/1ps
module asp_host
  import asp_pkg::*;
#(
  parameter int ADDR_W          = ADDR_WIDTH,
  parameter int DATA_W          = DATA_WIDTH,
  parameter bit FAST_GRADE      = 1'b1,
  parameter bit SLEEP_SUPPORTED = 1'b1
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // User request side.
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  input  wire logic              sleep_req,
  output logic                   asleep,
  // SRAM pins.
  output logic      [ADDR_W-1:0] sram_addr,
  output logic                   chip_select_low,
  output logic                   sleep_control,
  output logic                   write_strobe_low,
  output logic                   output_drive_enable_low,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe_n
);

  // Phase lengths in cycles; read and write pulse lengths depend on the grade.
  localparam int RD_ACCESS = cyc_max(
    cyc_min(FAST_GRADE ? ADDRESS_ACCESS_TIME_FAST_PS : ADDRESS_ACCESS_TIME_SLOW_PS),
    cyc_min(FAST_GRADE ? SELECT_ACCESS_TIME_FAST_PS : SELECT_ACCESS_TIME_SLOW_PS));
  // One extra cycle of margin before sampling the data pins.
  localparam int RD_CYC = cyc_max(RD_ACCESS,
    cyc_min(FAST_GRADE ? READ_CYCLE_MIN_FAST_PS : READ_CYCLE_MIN_SLOW_PS)) + 1;
  localparam int FLOAT_CYC = cyc_max(cyc_min(WRITE_START_TO_FLOAT_PS),
                                     cyc_min(OUTPUT_ENABLE_ACCESS_PS) - 1);
  localparam int WP_A = cyc_max(
    cyc_min(FAST_GRADE ? WRITE_PULSE_MIN_FAST_PS : WRITE_PULSE_MIN_SLOW_PS),
    cyc_min(FAST_GRADE ? SELECT_TO_END_FAST_PS : SELECT_TO_END_SLOW_PS));
  localparam int WP_B = cyc_max(
    cyc_min(FAST_GRADE ? WADDR_SETUP_TO_END_FAST_PS : WADDR_SETUP_TO_END_SLOW_PS),
    FLOAT_CYC + cyc_min(FAST_GRADE ? WDATA_SETUP_TO_END_FAST_PS
                                   : WDATA_SETUP_TO_END_SLOW_PS));
  localparam int WP_CYC = cyc_max(WP_A, WP_B);
  // Strobe stays high one hold cycle plus this many recovery cycles.
  localparam int REC_CYC = cyc_max(cyc_min(WRITE_RECOVERY_MIN_PS),
                                   cyc_min(WRITE_END_TO_DRIVE_PS));
  localparam int WAKE_CYC = cyc_max(cyc_min(WAKE_ACCESS_TIME_PS), cyc_min(SLEEP_TO_END_PS));

  // Timer reload values sized to the timer.
  localparam logic [TIMER_WIDTH-1:0] LD_READ = TIMER_WIDTH'(RD_CYC - 1);
  localparam logic [TIMER_WIDTH-1:0] LD_WP   = TIMER_WIDTH'(WP_CYC - 1);
  localparam logic [TIMER_WIDTH-1:0] LD_REC  = TIMER_WIDTH'(REC_CYC - 1);
  localparam logic [TIMER_WIDTH-1:0] LD_WAKE = TIMER_WIDTH'(WAKE_CYC - 1);
  localparam logic [TIMER_WIDTH-1:0] DRIVE_AT = TIMER_WIDTH'(WP_CYC - FLOAT_CYC);

  // Refuse shapes that the pins or the timer cannot serve.
  initial begin
    if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 1) begin
      $error("asp_host: unsupported address or data width");
    end
    if (WAKE_CYC >= (1 << TIMER_WIDTH) || RD_CYC >= (1 << TIMER_WIDTH)) begin
      $error("asp_host: phase length exceeds the timer");
    end
  end

  asp_state_t state;       // Current sequencer state.
  asp_state_t next_state;  // State for the next enabled edge.

  logic [TIMER_WIDTH-1:0] tmr_count;  // Cycles left in the current phase.
  logic                   tmr_done;   // Phase time has elapsed.

  // Sleep is only exercised on variants that have the pin function.
  wire sleep_ok = SLEEP_SUPPORTED & sleep_req;
  wire accept   = (state == ST_IDLE) & req_valid & req_ready;
  wire acc_rd   = accept & ~req_write;
  wire acc_wr   = accept & req_write;
  wire rd_end   = (state == ST_READ) & tmr_done;
  wire wp_end   = (state == ST_WPULSE) & tmr_done;
  wire go_sleep = (state == ST_IDLE) & ~req_valid & sleep_ok;
  wire go_wake  = (state == ST_SLEEP) & ~sleep_ok;
  wire to_wrec  = (state == ST_WHOLD);
  // Write data goes out only after the device has surely floated its drivers.
  wire drive_on = (state == ST_WPULSE) & (tmr_count == DRIVE_AT);

  // Timer load and reload value chosen by the entered phase.
  wire                   tmr_load = accept | to_wrec | go_wake;
  wire [TIMER_WIDTH-1:0] tmr_val  = acc_rd  ? LD_READ :
                                    acc_wr  ? LD_WP   :
                                    to_wrec ? LD_REC  : LD_WAKE;

  // Next-state selection; read, write pulse, recovery and wake end on the timer.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (acc_rd) begin
          next_state = ST_READ;
        end else if (acc_wr) begin
          next_state = ST_WPULSE;
        end else if (go_sleep) begin
          next_state = ST_SLEEP;
        end
      end
      ST_READ:   if (tmr_done) next_state = ST_IDLE;
      ST_WPULSE: if (tmr_done) next_state = ST_WHOLD;
      ST_WHOLD:  next_state = ST_WREC;
      ST_WREC:   if (tmr_done) next_state = ST_IDLE;
      ST_SLEEP:  if (go_wake) next_state = ST_WAKE;
      ST_WAKE:   if (tmr_done) next_state = ST_IDLE;
      default:   next_state = ST_WAKE;
    endcase
  end

  // Shared phase timer; reset starts a full wake wait after power-up.
  asp_timer #(
    .WIDTH     (TIMER_WIDTH),
    .RESET_VAL (LD_WAKE)
  ) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .load     (tmr_load),
    .load_val (tmr_val),
    .count    (tmr_count),
    .done     (tmr_done)
  );

  // Pin-level next values, all registered below.
  // Select stays low from a finished read into an idle cycle that takes another read.
  wire next_cs_low = acc_rd | acc_wr | (state == ST_READ) | (state == ST_WPULSE) |
                     (state == ST_WHOLD) |
                     ((state == ST_IDLE) & ~chip_select_low & req_valid);
  // Sleep control is high everywhere except the sleep state.
  wire next_sleep = ~(go_sleep | ((state == ST_SLEEP) & ~go_wake));
  wire next_we_low = acc_wr | ((state == ST_WPULSE) & ~tmr_done);
  // Device drivers are opened only during a read, never around a write.
  wire next_oe_low = acc_rd | ((state == ST_READ) & ~tmr_done);
  wire next_dq_oe_n = ~(drive_on | (~dq_oe_n & ~to_wrec));

  // Sequencer state and ready; ready is registered from the next state, so it is high exactly while the state is idle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_WAKE;
      req_ready <= 1'b0;
      asleep    <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      req_ready <= (next_state == ST_IDLE);
      asleep    <= (next_state == ST_SLEEP);
    end
  end

  // Control pins idle deselected with the device drivers shut.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_select_low         <= 1'b1;
      sleep_control           <= 1'b1;
      write_strobe_low        <= 1'b1;
      output_drive_enable_low <= 1'b1;
      dq_oe_n                 <= 1'b1;
    end else if (ce) begin
      chip_select_low         <= ~next_cs_low;
      sleep_control           <= next_sleep;
      write_strobe_low        <= ~next_we_low;
      output_drive_enable_low <= ~next_oe_low;
      dq_oe_n                 <= next_dq_oe_n;
    end
  end

  // Address and write data change only on acceptance, so they hold through the write.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_addr <= '0;
      dq_out    <= '0;
    end else if (ce && accept) begin
      sram_addr <= req_addr;
      dq_out    <= req_wdata;
    end
  end

  // Sample at the end of the read phase, past the slower of address and select access.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else if (ce) begin
      rsp_valid <= rd_end;
      if (rd_end) begin
        rsp_rdata <= dq_in;
      end
    end
  end

endmodule

// *** hdl/asp_pkg.sv ***
// Constants, state codes and cycle arithmetic for the asynchronous SRAM access port host.
package asp_pkg;

  // Clock period of core_clk in picoseconds.
  localparam int CLK_PERIOD_PS = 4000;

  // Read timing in picoseconds, fast grade then slow grade.
  localparam int ADDRESS_ACCESS_TIME_FAST_PS = 20000;
  localparam int ADDRESS_ACCESS_TIME_SLOW_PS = 25000;
  localparam int SELECT_ACCESS_TIME_FAST_PS  = 20000;
  localparam int SELECT_ACCESS_TIME_SLOW_PS  = 25000;
  localparam int READ_CYCLE_MIN_FAST_PS      = 20000;
  localparam int READ_CYCLE_MIN_SLOW_PS      = 25000;
  localparam int WAKE_ACCESS_TIME_PS         = 25000;
  localparam int OUTPUT_ENABLE_ACCESS_PS     = 5000;

  // Write timing in picoseconds, fast grade then slow grade.
  localparam int WRITE_PULSE_MIN_FAST_PS     = 15000;
  localparam int WRITE_PULSE_MIN_SLOW_PS     = 25000;
  localparam int SELECT_TO_END_FAST_PS       = 16000;
  localparam int SELECT_TO_END_SLOW_PS       = 20000;
  localparam int SLEEP_TO_END_PS             = 25000;
  localparam int WDATA_SETUP_TO_END_FAST_PS  = 12000;
  localparam int WDATA_SETUP_TO_END_SLOW_PS  = 15000;
  localparam int WADDR_SETUP_TO_END_FAST_PS  = 20000;
  localparam int WADDR_SETUP_TO_END_SLOW_PS  = 25000;
  localparam int WRITE_START_TO_FLOAT_PS     = 6000;
  localparam int WRITE_END_TO_DRIVE_PS       = 6000;
  localparam int WRITE_RECOVERY_MIN_PS       = 5000;

  // Documented pin widths.
  localparam int ADDR_WIDTH = 19;
  localparam int DATA_WIDTH = 8;

  // Width of the shared cycle timer.
  localparam int TIMER_WIDTH = 8;

  // One-hot sequencer states.
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_READ   = 7'h02,
    ST_WPULSE = 7'h04,
    ST_WHOLD  = 7'h08,
    ST_WREC   = 7'h10,
    ST_SLEEP  = 7'h20,
    ST_WAKE   = 7'h40
  } asp_state_t;

  // Least number of whole cycles covering a minimum time, never below one.
  function automatic int cyc_min(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Larger of two cycle counts.
  function automatic int cyc_max(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

endpackage

// *** hdl/asp_timer.sv ***
// Loadable down counter that paces the read, write pulse, recovery and wake phases of the SRAM sequencer.
`timescale 1ns/1ps
module asp_timer
  import asp_pkg::*;
#(
  parameter int                     WIDTH     = TIMER_WIDTH,
  parameter logic [TIMER_WIDTH-1:0] RESET_VAL = 8'h00
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] count,
  output logic                  done
);

  // Zero detect is combinational so the sequencer can leave on the last cycle.
  assign done = (count == '0);

  // A load wins over counting; the counter rests at zero until reloaded.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= RESET_VAL[WIDTH-1:0];
    end else if (ce) begin
      if (load) begin
        count <= load_val;
      end else if (!done) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// *** dv/asp_host_chk.sv ***
// Checker that watches the host's SRAM pin timing.
`timescale 1ns/1ps
module asp_host_chk #(
  parameter int ADDR_W     = 19,
  parameter int DATA_W     = 8,
  parameter bit FAST_GRADE = 1'b1
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] sram_addr,
  input wire logic              chip_select_low,
  input wire logic              sleep_control,
  input wire logic              write_strobe_low,
  input wire logic              output_drive_enable_low,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe_n
);
  // Least run lengths in 4 ns cycles, seen one edge after the strobe rises, or for RC one edge after the read address moves.
  localparam int WP = FAST_GRADE ? 4 : 7;
  localparam int CS = FAST_GRADE ? 4 : 5;
  localparam int DS = FAST_GRADE ? 3 : 4;
  localparam int AS = FAST_GRADE ? 4 : 6;
  localparam int RC = FAST_GRADE ? 4 : 6;
  logic [7:0] wcnt, ccnt, dcnt, scnt, acnt;  // Cycles each pin has held its state.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Counters saturate so that a long idle span never wraps into a short one.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {wcnt, ccnt, dcnt, scnt, acnt} <= 40'h0;
    end else begin
      wcnt <= write_strobe_low ? 8'h00 : wcnt + {7'h00, wcnt != 8'hFF};
      ccnt <= chip_select_low ? 8'h00 : ccnt + {7'h00, ccnt != 8'hFF};
      dcnt <= dq_oe_n ? 8'h00 : dcnt + {7'h00, dcnt != 8'hFF};
      scnt <= !sleep_control ? 8'h00 : scnt + {7'h00, scnt != 8'hFF};
      acnt <= $changed(sram_addr) ? 8'h00 : acnt + {7'h00, acnt != 8'hFF};
    end
  end
  strobe_select_a: assert property (
    !write_strobe_low |-> !chip_select_low && sleep_control)
    else $error("strobe low while deselected");
  pulse_width_a: assert property ($rose(write_strobe_low) |-> wcnt >= WP)
    else $error("write pulse too short");
  select_setup_a: assert property (
    $rose(write_strobe_low) |-> ccnt >= CS && scnt >= 7)
    else $error("select or wake too late before write end");
  data_setup_a: assert property (
    $rose(write_strobe_low) |-> dcnt >= DS && !dq_oe_n && $stable(dq_out))
    else $error("write data setup or hold short");
  addr_setup_a: assert property (
    $rose(write_strobe_low) |-> acnt >= AS && $stable(sram_addr))
    else $error("write address setup short");
  addr_hold_a: assert property ($past(!write_strobe_low) |-> $stable(sram_addr))
    else $error("address moved during write");
  write_recovery_a: assert property (
    $rose(write_strobe_low) |-> write_strobe_low [*2])
    else $error("write recovery too short");
  read_space_a: assert property (
    $changed(sram_addr) && !chip_select_low && !$past(chip_select_low) |-> acnt >= RC)
    else $error("read cycles too close");
  select_addr_a: assert property (
    $fell(chip_select_low) |=> $stable(sram_addr) [*4])
    else $error("address moved after select");
  no_contend_a: assert property (!dq_oe_n |-> output_drive_enable_low)
    else $error("host drives while device may drive");
  cover property ($rose(write_strobe_low));
  cover property ($changed(sram_addr) && !chip_select_low && !$past(chip_select_low));
  cover property ($fell(sleep_control));
endmodule
bind asp_host asp_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .FAST_GRADE(FAST_GRADE))
  asp_host_chk_inst (.core_clk, .rst_n, .sram_addr, .chip_select_low, .sleep_control,
  .write_strobe_low, .output_drive_enable_low, .dq_out, .dq_oe_n);

// *** dv/asp_sram_model.sv ***
// Behavioural asynchronous SRAM that answers the host on its pins.
`timescale 1ns/1ps
module asp_sram_model #(
  parameter int ACC_NS    = 20,   // Address and select access time.
  parameter bit SLEEP_SUP = 1'b1  // Variant carries the sleep pin.
) (
  input  wire logic [18:0] sram_addr,
  input  wire logic        chip_select_low,
  input  wire logic        sleep_control,
  input  wire logic        write_strobe_low,
  input  wire logic        output_drive_enable_low,
  input  wire logic [7:0]  dq,
  output logic      [7:0]  dev_q
);
  logic [7:0] mem [0:524287];  // Storage, unknown until written.
  logic [7:0] rd;              // Array word, settling after each address move.
  logic       drv, sel_ok;     // Drivers on; select has been low long enough.
  logic [18:0] wa;             // Address as it stood just before the latest pin move.
  logic [7:0]  wd;             // Data as it stood just before the latest pin move.
  wire awake = SLEEP_SUP ? sleep_control : 1'b1;
  wire sel   = !chip_select_low && awake;
  wire wwin  = sel && !write_strobe_low;
  // Inertial delay keeps old data until the last address change has settled.
  assign #(ACC_NS) rd = mem[sram_addr];
  assign #(ACC_NS) sel_ok = sel;
  // A read needs select and wake with the strobe high; drivers stay shut through a write.
  wire rd_en = sel && write_strobe_low;
  assign #4 drv = rd_en && !output_drive_enable_low;
  // Hold is zero, so pins that move in the very instant the window closes are not taken.
  assign #0.1 wa = sram_addr;
  assign #0.1 wd = dq;
  // Undriven or unsettled lines show the inverse so a stale sample cannot pass.
  assign dev_q = (drv && sel_ok) ? rd : ~rd;
  // The word is taken as the write window closes, whichever pin closes it.
  always @(negedge wwin) begin
    mem[wa] = wd;
  end
endmodule

// *** dv/tb_async_sram_access_port.sv ***
// Bench that runs the SRAM host against a pin-level memory model.
`timescale 1ns/1ps
module tb_async_sram_access_port;
  // A row is one request with the read data it should return.
  typedef struct {
    logic        w;
    logic [18:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
  } asp_row_t;
  asp_row_t rows [8] = '{
    '{1'b1, 19'h00000, 8'hA5, 8'h00}, '{1'b1, 19'h7FFFF, 8'h3C, 8'h00},
    '{1'b1, 19'h00001, 8'h5A, 8'h00}, '{1'b0, 19'h00000, 8'h00, 8'hA5},
    '{1'b0, 19'h7FFFF, 8'h00, 8'h3C}, '{1'b1, 19'h00000, 8'hC3, 8'h00},
    '{1'b0, 19'h00000, 8'h00, 8'hC3}, '{1'b0, 19'h00001, 8'h00, 8'h5A}};
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic        ce        = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        sleep_req = 1'b0;
  logic [18:0] req_addr  = 19'h00000;
  logic [7:0]  req_wdata = 8'h00;
  logic        req_ready, rsp_valid, asleep, chip_select_low, sleep_control;
  logic        write_strobe_low, output_drive_enable_low, dq_oe_n;
  logic [18:0] sram_addr;
  logic [7:0]  rsp_rdata, dq_out, dev_q;
  wire  [7:0]  dq_in = dq_oe_n ? dev_q : dq_out;  // Host owns the lines only when enabled.
  logic [7:0]  expq [$];  // Read data still owed by the host.
  int          err_count = 0;
  int          compares  = 0;
  asp_host #(.FAST_GRADE(1'b1)) asp_host_inst (
    .core_clk, .rst_n, .ce, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
    .rsp_valid, .rsp_rdata, .sleep_req, .asleep, .sram_addr, .chip_select_low,
    .sleep_control, .write_strobe_low, .output_drive_enable_low, .dq_in, .dq_out, .dq_oe_n);
  asp_sram_model #(.ACC_NS(20)) asp_sram_model_inst (
    .sram_addr, .chip_select_low, .sleep_control, .write_strobe_low,
    .output_drive_enable_low, .dq(dq_in), .dev_q);
  always #2 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request is held from a falling edge until the edge that takes it.
  task automatic send(input logic w, input logic [18:0] a, input logic [7:0] d);
    @(negedge core_clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr  = a;
    req_wdata = d;
    while (req_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic complete_run();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Each one-cycle response is matched against the oldest owed read.
  always @(negedge core_clk) if (rsp_valid === 1'b1) chk(rsp_rdata, expq.pop_front());
  initial begin
    #20000;
    err_count++;
    complete_run();
  end
  initial begin
    int n;
    n = 0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk({2'h0, chip_select_low, sleep_control, write_strobe_low, output_drive_enable_low,
         dq_oe_n, req_ready}, 8'h3E);
    rst_n = 1'b1;
    while (req_ready !== 1'b1) begin
      @(negedge core_clk);
      n++;
    end
    chk(n[7:0], 8'h07);
    $display("test reset done");
    // Rows go back to back, so reads follow writes with no idle gap.
    foreach (rows[i]) begin
      if (!rows[i].w) expq.push_back(rows[i].e);
      send(rows[i].w, rows[i].a, rows[i].d);
    end
    req_valid = 1'b0;
    while (expq.size() != 0) @(negedge core_clk);
    $display("test table done");
    // A frozen clock enable must leave a waiting request untaken.
    // Two idle edges first, so select has surely been released before the freeze.
    repeat (2) @(negedge core_clk);
    ce = 1'b0;
    expq.push_back(8'h5A);
    req_valid = 1'b1;
    req_write = 1'b0;
    req_addr  = 19'h00001;
    repeat (4) @(negedge core_clk);
    chk({7'h00, chip_select_low}, 8'h01);
    ce = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    while (expq.size() != 0) @(negedge core_clk);
    $display("test clock enable done");
    sleep_req = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({6'h00, asleep, sleep_control}, 8'h02);
    sleep_req = 1'b0;
    expq.push_back(8'h3C);
    send(1'b0, 19'h7FFFF, 8'h00);
    req_valid = 1'b0;
    while (expq.size() != 0) @(negedge core_clk);
    $display("test sleep done");
    // Reset lands in mid-write; the pins must let go at once.
    req_valid = 1'b1;
    req_write = 1'b1;
    req_addr  = 19'h00001;
    req_wdata = 8'hEE;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b0;
    req_valid = 1'b0;
    #1 chk({5'h00, chip_select_low, write_strobe_low, dq_oe_n}, 8'h07);
    @(negedge core_clk);
    rst_n = 1'b1;
    expq.push_back(8'hC3);
    send(1'b0, 19'h00000, 8'h00);
    req_valid = 1'b0;
    while (expq.size() != 0) @(negedge core_clk);
    $display("test reset in write done");
    complete_run();
  end
endmodule
